/* File: src/bsi_regs.vh */
// Constants of the busy/status indicator: sizes, mode codes, timing counts.
// Assumes a single 40 MHz module clock; times are kept in their own unit
// and converted to cycles here.
`ifndef BSI_REGS_VH
`define BSI_REGS_VH

// ****************************************************************
// Clock
// ****************************************************************
`define BSI_CLK_KHZ        40000

// ****************************************************************
// Buffers
// ****************************************************************
`define BSI_BUF_BYTES      512
`define BSI_BUF_AW         9
`define BSI_CNT_W          10
`define BSI_PKT_BYTES      10'h03a
`define BSI_FIFO_DEPTH     8
`define BSI_FIFO_AW        3
`define BSI_BYTE_W         8

// ****************************************************************
// Operating modes
// ****************************************************************
`define BSI_MODE_W         2
`define BSI_MODE_NORMAL    2'h0
`define BSI_MODE_SLEEP     2'h3

// ****************************************************************
// Timing: figures in their unit, then cycle counts
// ****************************************************************
`define BSI_TMR_W          28
// Self-check and parameter reload duration (least)
`define BSI_SELFCHECK_US   5000
`define BSI_SELFCHECK_CYC  ((`BSI_SELFCHECK_US*`BSI_CLK_KHZ+999)/1000)
// Deferred mode change, least time after the busy output rises
`define BSI_DEFER_US       2000
`define BSI_DEFER_CYC      ((`BSI_DEFER_US*`BSI_CLK_KHZ+999)/1000)
// Silence on the host input that ends a partial packet (longest)
`define BSI_GAP_US         3000
`define BSI_GAP_CYC        ((`BSI_GAP_US*`BSI_CLK_KHZ)/1000)
// Wake-up lead of the busy output before serial output data (least)
`define BSI_WAKE_US        10
`define BSI_WAKE_CYC       ((`BSI_WAKE_US*`BSI_CLK_KHZ+999)/1000)
// Fault indicator base blink period
`define BSI_BLINK_MS       500
`define BSI_BLINK_CYC      (`BSI_BLINK_MS*`BSI_CLK_KHZ)

`endif

/* File: src/bsi_mem.v */
// Transmit byte store: one write port, one read port, registered read.
// Assumes the caller never reads an entry in the cycle it is written.
module bsi_mem (
  input  wire                   mclk,
  input  wire                   wr_en,
  input  wire [8:0]             wr_addr,
  input  wire [7:0]             wr_data,
  input  wire                   rd_en,
  input  wire [8:0]             rd_addr,
  output reg  [7:0]             rd_data
);

  reg [7:0] store [0:511];

  always @(posedge mclk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    // Read data holds until the next read, so the consumer may stall
    if (rd_en) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule

/* File: src/bsi_fifo.v */
// Small first-in first-out queue with valid/ready on both sides.
// Assumes both sides run on mclk; full and empty are exact.
module bsi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire                   mclk,
  input  wire                   reset,
  input  wire                   in_valid,
  output wire                   in_ready,
  input  wire [WIDTH-1:0]       in_data,
  output wire                   out_valid,
  input  wire                   out_ready,
  output wire [WIDTH-1:0]       out_data
);

  reg [WIDTH-1:0] slot [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;

  localparam [AW:0] FIFO_FULL = DEPTH[AW:0];

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill != FIFO_FULL);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = slot[rd_ptr];

  always @(posedge mclk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        slot[wr_ptr] <= in_data;
        wr_ptr       <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

/* File: src/bsi_top.v */
// Busy/status indicator of a serial-to-radio module: transmit buffer with
// automatic packetisation, receive queue toward the serial output and the
// self-check phase, all folded into one busy output; mode selection waits on it.
// Assumes the serial receiver, serial transmitter and radio chip interface
// sit outside on mclk; mode and fault pins arrive asynchronously.
`include "bsi_regs.vh"

// Function
// [R01] One busy output reports three conditions
// [R02] Busy low while transmit buffer holds data
// [R03] Buffer drained to radio in packets
// [R04] Host stream accepted without overflow
// [R05] Busy may rise once last packet written
// [R06] Busy low until received data fully output
// [R07] Busy falls ahead of serial output data
// [R08] Self-check only at reset or sleep exit
// [R09] Any low condition wins over high
// [R10] Mode pins ignored while busy is low
// [R11] Mode switch completes with busy rising
// [R12] Deferred mode applied 2 ms after rise
// [R13] Mode change while idle applies at once
// [R14] Sleep exit or reset reloads parameters
// [R15] Fault pin blinks per abnormal condition
// [R16] Host avoids large volumes at low rate
// [R17] Power-up: busy low, check, then high
// [R18] Host waits for busy rise after reset
// [R19] Two mode pins choose four modes
// [R20] Host holds pins until busy rises
module bsi_top #(
  parameter [27:0] SELFCHECK_CYC = `BSI_SELFCHECK_CYC,
  parameter [27:0] DEFER_CYC     = `BSI_DEFER_CYC,
  parameter [27:0] GAP_CYC       = `BSI_GAP_CYC,
  parameter [27:0] BLINK_CYC     = `BSI_BLINK_CYC
) (
  input  wire                   mclk,
  input  wire                   reset,
  input  wire                   cmd_reset,
  input  wire                   host_byte_valid,
  input  wire [7:0]             host_byte_data,
  output wire                   host_byte_ready,
  output wire                   radio_valid,
  output wire [7:0]             radio_data,
  output wire                   radio_last,
  input  wire                   radio_ready,
  input  wire                   air_valid,
  input  wire [7:0]             air_data,
  output wire                   air_ready,
  output wire                   ser_valid,
  output wire [7:0]             ser_data,
  input  wire                   ser_ready,
  input  wire                   ser_active,
  input  wire                   mode_select_lo,
  input  wire                   mode_select_hi,
  input  wire                   volt_low,
  input  wire                   volt_high,
  output reg                    busy_n,
  output reg  [1:0]             active_mode,
  output reg                    param_reload,
  output wire                   self_check,
  output reg                    fault_led
);

  // ****************************************************************
  // Local codes
  // ****************************************************************
  localparam [2:0] CT_INIT  = 3'h1;
  localparam [2:0] CT_RUN   = 3'h2;
  localparam [2:0] CT_DEFER = 3'h4;

  localparam [2:0] TX_IDLE  = 3'h1;
  localparam [2:0] TX_FETCH = 3'h2;
  localparam [2:0] TX_PUSH  = 3'h4;

  localparam [9:0]  BUF_FULL = `BSI_BUF_BYTES;
  localparam [9:0]  PKT_MAX  = `BSI_PKT_BYTES;
  localparam [15:0] WAKE_CYC = `BSI_WAKE_CYC;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [3:0] pin_raw = {volt_high, volt_low, mode_select_hi, mode_select_lo};
  reg  [3:0] pin_meta;
  reg  [3:0] pin_sync;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (reset) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Two pins pick one of four modes
  wire [1:0] pin_mode = pin_sync[1:0]; // see [R19]
  wire       fault_lo = pin_sync[2];
  wire       fault_hi = pin_sync[3];

  // ****************************************************************
  // Transmit buffer and packetiser
  // ****************************************************************
  reg  [2:0] tx_state;
  reg  [8:0] wr_ptr;
  reg  [8:0] rd_ptr;
  reg  [9:0] buf_count;
  reg  [9:0] pkt_left;
  reg [27:0] gap_cnt;
  wire       tx_busy;
  reg  [2:0] ctl_state;
  wire       in_init = ctl_state[0];

  // Back-pressure keeps a long host stream from overrunning the store
  assign host_byte_ready = (buf_count != BUF_FULL) & ~in_init; // see [R04]

  wire buf_wr = host_byte_valid & host_byte_ready;
  wire buf_rd = tx_state[2] & radio_ready;
  wire mem_rd = tx_state[1];

  bsi_mem u_mem (
    .mclk    (mclk),
    .wr_en   (buf_wr),
    .wr_addr (wr_ptr),
    .wr_data (host_byte_data),
    .rd_en   (mem_rd),
    .rd_addr (rd_ptr),
    .rd_data (radio_data)
  );

  assign radio_valid = tx_state[2];
  assign radio_last  = tx_state[2] & (pkt_left == 10'h001);

  // A full packet goes at once; a partial one waits for host silence
  wire pkt_full  = (buf_count >= PKT_MAX);
  wire pkt_quiet = (buf_count != 10'h000) & (gap_cnt >= GAP_CYC);
  wire pkt_go    = tx_state[0] & (pkt_full | pkt_quiet);

  always @(posedge mclk) begin
    if (reset) begin
      tx_state  <= TX_IDLE;
      wr_ptr    <= 9'h000;
      rd_ptr    <= 9'h000;
      buf_count <= 10'h000;
      pkt_left  <= 10'h000;
      gap_cnt   <= 28'h0000000;
    end else begin
      if (buf_wr) begin
        wr_ptr  <= wr_ptr + 9'h001;
        gap_cnt <= 28'h0000000;
      end else if (gap_cnt < GAP_CYC) begin
        gap_cnt <= gap_cnt + 28'h0000001;
      end
      if (buf_rd) begin
        rd_ptr <= rd_ptr + 9'h001;
      end
      if (buf_wr & ~buf_rd) begin
        buf_count <= buf_count + 10'h001;
      end else if (buf_rd & ~buf_wr) begin
        buf_count <= buf_count - 10'h001;
      end
      case (tx_state)
        TX_IDLE: begin
          if (pkt_go) begin // see [R03]
            pkt_left <= pkt_full ? PKT_MAX : buf_count;
            tx_state <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          tx_state <= TX_PUSH;
        end
        TX_PUSH: begin
          if (radio_ready) begin
            pkt_left <= pkt_left - 10'h001;
            // Air time of the last packet is not waited for
            if (pkt_left == 10'h001) begin // see [R05]
              tx_state <= TX_IDLE;
            end else begin
              tx_state <= TX_FETCH;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Busy while bytes remain or a packet is being written
  assign tx_busy = (buf_count != 10'h000) | ~tx_state[0]; // see [R02]

  // ****************************************************************
  // Receive queue toward the serial output
  // ****************************************************************
  wire        q_valid;
  wire        q_ready;
  reg  [15:0] wake_cnt;
  wire        wake_done = (wake_cnt == WAKE_CYC);
  wire        rx_busy;

  bsi_fifo #(
    .WIDTH (`BSI_BYTE_W),
    .DEPTH (`BSI_FIFO_DEPTH),
    .AW    (`BSI_FIFO_AW)
  ) u_rxq (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (air_valid),
    .in_ready  (air_ready),
    .in_data   (air_data),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (ser_data)
  );

  // Output is held back until the busy edge has had time to wake the host
  assign ser_valid = q_valid & wake_done; // see [R07]
  assign q_ready   = ser_ready & wake_done;

  always @(posedge mclk) begin
    if (reset) begin
      wake_cnt <= 16'h0000;
    end else if (~q_valid & ~ser_active) begin
      wake_cnt <= 16'h0000;
    end else if (~wake_done) begin
      wake_cnt <= wake_cnt + 16'h0001;
    end
  end

  // Busy until the last bit has left the serial line
  assign rx_busy = q_valid | ser_active; // see [R06]

  // ****************************************************************
  // Self-check and mode control
  // ****************************************************************
  reg [27:0] init_cnt;
  reg [27:0] defer_cnt;
  reg        busy_prev;

  wire busy_rise = busy_n & ~busy_prev;
  wire mode_diff = (pin_mode != active_mode);
  wire from_sleep = (active_mode == `BSI_MODE_SLEEP);

  assign self_check = in_init;

  always @(posedge mclk) begin
    if (reset) begin
      // Power-on: start in the check phase with busy held low
      ctl_state    <= CT_INIT; // see [R17]
      init_cnt     <= 28'h0000000;
      defer_cnt    <= 28'h0000000;
      active_mode  <= `BSI_MODE_NORMAL;
      param_reload <= 1'b0;
      busy_prev    <= 1'b0;
    end else begin
      busy_prev    <= busy_n;
      // One reload pulse at the start of every check phase
      param_reload <= in_init & (init_cnt == 28'h0000000); // see [R14]
      if (cmd_reset) begin
        ctl_state <= CT_INIT; // see [R08]
        init_cnt  <= 28'h0000000;
      end else begin
        case (ctl_state)
          CT_INIT: begin
            if (init_cnt >= SELFCHECK_CYC - 28'h0000001) begin
              ctl_state   <= CT_RUN;
              active_mode <= pin_mode;
            end else begin
              init_cnt <= init_cnt + 28'h0000001;
            end
          end
          CT_RUN: begin
            // Pins are looked at only while busy is high
            if (busy_n & mode_diff) begin // see [R10]
              if (busy_rise) begin
                ctl_state <= CT_DEFER; // see [R12]
                defer_cnt <= 28'h0000000;
              end else begin
                active_mode <= pin_mode; // see [R13]
                if (from_sleep) begin
                  ctl_state <= CT_INIT; // see [R08]
                  init_cnt  <= 28'h0000000;
                end
              end
            end
          end
          CT_DEFER: begin
            // A renewed busy period restarts the wait
            if (~busy_n) begin
              defer_cnt <= 28'h0000000;
            end else if (defer_cnt >= DEFER_CYC - 28'h0000001) begin
              active_mode <= pin_mode; // see [R11]
              if (from_sleep & mode_diff) begin
                ctl_state <= CT_INIT; // see [R14]
                init_cnt  <= 28'h0000000;
              end else begin
                ctl_state <= CT_RUN;
              end
            end else begin
              defer_cnt <= defer_cnt + 28'h0000001;
            end
          end
          default: begin
            ctl_state <= CT_INIT;
            init_cnt  <= 28'h0000000;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Busy output
  // ****************************************************************
  // Registered so the pin never glitches between conditions
  always @(posedge mclk) begin
    if (reset) begin
      busy_n <= 1'b0;
    end else begin
      busy_n <= ~(in_init | tx_busy | rx_busy); // see [R01] see [R09]
    end
  end

  // ****************************************************************
  // Fault indicator
  // ****************************************************************
  reg [27:0] blink_cnt;
  reg        blink_half;

  wire blink_tick = (blink_cnt >= BLINK_CYC - 28'h0000001);

  always @(posedge mclk) begin
    if (reset) begin
      blink_cnt  <= 28'h0000000;
      blink_half <= 1'b0;
      fault_led  <= 1'b0;
    end else begin
      if (blink_tick) begin
        blink_cnt  <= 28'h0000000;
        blink_half <= ~blink_half;
      end else begin
        blink_cnt <= blink_cnt + 28'h0000001;
      end
      // Overvoltage toggles every second tick, undervoltage every tick
      if (fault_hi) begin
        if (blink_tick & blink_half) begin
          fault_led <= ~fault_led; // see [R15]
        end
      end else if (fault_lo) begin
        if (blink_tick) begin
          fault_led <= ~fault_led; // see [R15]
        end
      end else begin
        fault_led <= 1'b0;
      end
    end
  end

endmodule

/* File: sim/bsi_monitor.sv */
// Checker of the busy indicator, bound to every bsi_top.
// Assumes one clock domain and a self-check of at least nine cycles.
module bsi_monitor (
  input logic       mclk,
  input logic       reset,
  input logic       host_byte_ready,
  input logic       radio_valid,
  input logic [7:0] radio_data,
  input logic       radio_last,
  input logic       radio_ready,
  input logic       air_valid,
  input logic       air_ready,
  input logic       ser_valid,
  input logic [7:0] ser_data,
  input logic       ser_ready,
  input logic       busy_n,
  input logic [1:0] active_mode,
  input logic       param_reload,
  input logic       self_check
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ******
  // Busy sources
  // ******
  a_check_busy: assert property (self_check |=> !busy_n)
    else $error("busy high during self-check");
  a_check_ready: assert property (
    self_check |-> !host_byte_ready)
    else $error("host bytes taken during self-check");
  a_reload_once: assert property (
    param_reload |=> !param_reload && self_check)
    else $error("reload pulse not single");
  a_check_span: assert property (
    $rose(param_reload) |-> self_check [*8])
    else $error("self-check ended too soon");
  a_tx_busy: assert property (radio_valid |-> !busy_n)
    else $error("busy high while packet sent");
  a_rx_busy: assert property (
    air_valid && air_ready |-> ##2 !busy_n)
    else $error("busy high after received byte");
  a_wake_lead: assert property (
    $rose(ser_valid) |-> !$past(busy_n, 8))
    else $error("serial data without wake lead");
  // ******
  // Transfers and mode
  // ******
  a_radio_hold: assert property (
    radio_valid && !radio_ready |=> radio_valid && $stable(radio_data)
      && $stable(radio_last))
    else $error("radio byte dropped before taken");
  a_ser_hold: assert property (
    ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
    else $error("serial byte dropped before taken");
  a_mode_frozen: assert property (
    !busy_n && !self_check |=> $stable(active_mode))
    else $error("mode changed while busy");
endmodule

bind bsi_top bsi_monitor u_bsi_monitor (.mclk, .reset, .host_byte_ready,
  .radio_valid, .radio_data, .radio_last, .radio_ready, .air_valid,
  .air_ready, .ser_valid, .ser_data, .ser_ready, .busy_n, .active_mode,
  .param_reload, .self_check);

/* File: sim/bsi_host.sv */
// Host model: serial byte source and the two mode pins.
// Assumes a byte is taken at a rising edge with valid and ready high.
module bsi_host (
  input  wire        mclk,
  input  wire        host_byte_ready,
  output logic       host_byte_valid,
  output logic [7:0] host_byte_data,
  output logic       mode_select_lo,
  output logic       mode_select_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_byte_valid = 1'b0;
    host_byte_data = 8'hff;
    {mode_select_hi, mode_select_lo} = 2'h0;
  end
  // Short bursts only: a backlog would stall on host_byte_ready at low air rates
  task automatic send(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      host_byte_valid <= 1'b1;
      host_byte_data <= base + 8'(i);
      do @(negedge mclk); while (host_byte_ready !== 1'b1);
      @(posedge mclk);
    end
    host_byte_valid <= 1'b0;
    // Released data is not left showing the last byte
    host_byte_data <= ~host_byte_data;
  endtask
  task automatic set_mode(input logic [1:0] m);
    {mode_select_hi, mode_select_lo} <= m;
  endtask
endmodule

/* File: sim/testbench.sv */
// Self-checking bench of bsi_top with host, radio and serializer sides.
// Assumes shortened self-check, defer, gap and blink counts.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, reset, cmd_reset, radio_ready, air_valid, ser_ready;
  logic       volt_low, volt_high, ser_en = 1'b0;
  logic [7:0] air_data;
  logic [1:0] stall = 2'h0;
  logic [3:0] ser_tmr = 4'h0;
  wire        host_byte_valid, host_byte_ready, radio_valid, radio_last;
  wire        air_ready, ser_valid, ser_active, busy_n, param_reload;
  wire        self_check, fault_led, mode_select_lo, mode_select_hi;
  wire  [7:0] host_byte_data, radio_data, ser_data;
  wire  [1:0] active_mode;
  int         err_count = 0, checked = 0, rad_cnt = 0, rad_n = 0;
  int         rad_bursts = 0, ser_seen = 0;

  bsi_top #(.SELFCHECK_CYC(28'd20), .DEFER_CYC(28'd30), .GAP_CYC(28'd16),
    .BLINK_CYC(28'd8)) u_bsi_top (.mclk, .reset, .cmd_reset,
    .host_byte_valid, .host_byte_data, .host_byte_ready, .radio_valid,
    .radio_data, .radio_last, .radio_ready, .air_valid, .air_data,
    .air_ready, .ser_valid, .ser_data, .ser_ready, .ser_active,
    .mode_select_lo, .mode_select_hi, .volt_low, .volt_high, .busy_n,
    .active_mode, .param_reload, .self_check, .fault_led);
  bsi_host u_bsi_host (.mclk, .host_byte_ready, .host_byte_valid,
    .host_byte_data, .mode_select_lo, .mode_select_hi);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ******
  // Radio chip and serializer stand-ins
  // ******
  always @(posedge mclk) begin
    stall <= stall + 2'h1;
    radio_ready <= (stall != 2'h3);
    if (radio_valid === 1'b1 && radio_ready === 1'b1) begin
      check(radio_data, 8'h10 + 8'(rad_cnt));
      check(radio_last, rad_cnt == 57 || rad_cnt == rad_n - 1);
      if (rad_cnt == rad_n - 1) begin
        rad_cnt <= 0;
        rad_bursts <= rad_bursts + 1;
      end else begin
        rad_cnt <= rad_cnt + 1;
      end
    end
    // A taken byte keeps the serializer busy for its whole frame
    ser_ready <= ser_en && ser_tmr == 4'h0
      && !(ser_valid === 1'b1 && ser_ready === 1'b1);
    if (ser_valid === 1'b1 && ser_ready === 1'b1) begin
      check(ser_data, 8'h40 + 8'(ser_seen));
      ser_seen <= ser_seen + 1;
      ser_tmr <= 4'h9;
    end else if (ser_tmr != 4'h0) begin
      ser_tmr <= ser_tmr - 4'h1;
    end
  end
  assign ser_active = (ser_tmr != 4'h0);
  // ******
  // Helpers
  // ******
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (busy_n !== lvl && n < lim);
    check(busy_n, lvl);
  endtask
  task automatic toggles(output int n);
    logic prev;
    n = 0;
    @(negedge mclk);
    prev = fault_led;
    repeat (48) begin
      @(negedge mclk);
      if (fault_led !== prev) n++;
      prev = fault_led;
    end
  endtask
  // ******
  // Scenarios
  // ******
  task automatic t_power;
    check(busy_n, 1'b0);
    check(host_byte_ready, 1'b0);
    wait_busy(1'b1, 60);
    check(active_mode, 2'h0);
    check(host_byte_ready, 1'b1);
  endtask
  task automatic t_tx;
    rad_n = 60;
    @(posedge mclk);
    u_bsi_host.send(60, 8'h10);
    check(busy_n, 1'b0);
    wait_busy(1'b1, 400);
    check(8'(rad_bursts), 8'd1);
    check(8'(rad_cnt), 8'd0);
  endtask
  task automatic t_rx;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      air_valid <= 1'b1;
      air_data <= 8'h40 + 8'(i);
      @(negedge mclk);
      check(air_ready, i < 8);
      @(posedge mclk);
    end
    air_valid <= 1'b0;
    air_data <= 8'hb7;
    check(busy_n, 1'b0);
    ser_en <= 1'b1;
    wait_busy(1'b1, 1200);
    check(8'(ser_seen), 8'd8);
  endtask
  task automatic t_mode_now;
    @(posedge mclk);
    u_bsi_host.set_mode(2'h1);
    repeat (5) @(negedge mclk);
    check(active_mode, 2'h1);
    check(busy_n, 1'b1);
  endtask
  // Defer window is 30 cycles of busy high, counted from the rise
  task automatic t_defer;
    rad_n = 10;
    @(posedge mclk);
    u_bsi_host.send(10, 8'h10);
    u_bsi_host.set_mode(2'h2);
    wait_busy(1'b1, 300);
    check(active_mode, 2'h1);
    repeat (29) @(negedge mclk);
    check(active_mode, 2'h1);
    repeat (3) @(negedge mclk);
    check(active_mode, 2'h2);
    check(8'(rad_bursts), 8'd2);
  endtask
  task automatic t_sleep;
    @(posedge mclk);
    u_bsi_host.set_mode(2'h3);
    repeat (5) @(negedge mclk);
    check(active_mode, 2'h3);
    @(posedge mclk);
    u_bsi_host.set_mode(2'h0);
    repeat (7) @(negedge mclk);
    check(busy_n, 1'b0);
    wait_busy(1'b1, 60);
    check(active_mode, 2'h0);
  endtask
  task automatic t_cmd;
    @(posedge mclk);
    cmd_reset <= 1'b1;
    @(posedge mclk);
    cmd_reset <= 1'b0;
    @(negedge mclk);
    check(self_check, 1'b1);
    check(host_byte_ready, 1'b0);
    @(negedge mclk);
    check(busy_n, 1'b0);
    check(param_reload, 1'b1);
    wait_busy(1'b1, 60);
  endtask
  task automatic t_fault;
    int n;
    @(posedge mclk);
    volt_low <= 1'b1;
    toggles(n);
    check(n >= 4 && n <= 6, 1'b1);
    @(posedge mclk);
    volt_high <= 1'b1;
    toggles(n);
    check(n >= 2 && n <= 4, 1'b1);
    @(posedge mclk);
    volt_low <= 1'b0;
    volt_high <= 1'b0;
    repeat (5) @(negedge mclk);
    check(fault_led, 1'b0);
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Generous bound: the whole sequence needs about 1000 cycles
  initial begin
    #(20000 * 25);
    err_count++;
    finish_test();
  end
  initial begin
    reset <= 1'b1;
    cmd_reset <= 1'b0;
    air_valid <= 1'b0;
    air_data <= 8'h00;
    volt_low <= 1'b0;
    volt_high <= 1'b0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    t_power();
    t_tx();
    t_rx();
    t_mode_now();
    t_defer();
    t_sleep();
    t_cmd();
    t_fault();
    finish_test();
  end
endmodule
